// ===== include/sarc_pkg.sv
// Purpose: Shared constants and carriers for the converter control block.
// Assumes: One system clock at 40 MHz.
// Notes: Field codes follow the control bit encodings used by software.
package sarc_pkg;

    localparam int SYS_CLK_HZ = 40000000;
    localparam int INSTR_CYCLE_NS = 100;
    localparam int INSTR_CYCLE_CLKS = (INSTR_CYCLE_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
    localparam logic [3:0] RC_WAIT_LOAD = 4'(INSTR_CYCLE_CLKS - 1);

    localparam int MAG_BITS = 12;
    localparam logic [3:0] PHASE_SAMPLE = 4'h0;
    localparam logic [3:0] PHASE_SIGN = 4'h1;
    localparam logic [3:0] PHASE_MSB = 4'h2;
    localparam logic [3:0] PHASE_LAST = 4'hE;
    localparam logic [3:0] MAG_TOP = 4'hB;

    localparam logic [3:0] NEG_SINGLE_ENDED = 4'hF;

    localparam logic [1:0] PREF_SUPPLY = 2'h0;
    localparam logic [1:0] PREF_PIN = 2'h1;
    localparam logic [1:0] PREF_RESERVED = 2'h2;
    localparam logic [1:0] PREF_FIXED = 2'h3;

    localparam logic [2:0] REF_SEL_SUPPLY = 3'h1;
    localparam logic [2:0] REF_SEL_PIN = 3'h2;
    localparam logic [2:0] REF_SEL_FIXED = 3'h4;
    localparam logic [2:0] REF_SEL_NONE = 3'h0;

    localparam logic [1:0] CLK_RC_CODE = 2'h3;
    localparam logic [2:0] CLK_DIV2 = 3'h0;
    localparam logic [2:0] CLK_DIV4 = 3'h4;
    localparam logic [2:0] CLK_DIV8 = 3'h1;
    localparam logic [2:0] CLK_DIV16 = 3'h5;
    localparam logic [2:0] CLK_DIV32 = 3'h2;
    localparam logic [2:0] CLK_DIV64 = 3'h6;

    localparam logic [5:0] DIV2_LOAD = 6'h01;
    localparam logic [5:0] DIV4_LOAD = 6'h03;
    localparam logic [5:0] DIV8_LOAD = 6'h07;
    localparam logic [5:0] DIV16_LOAD = 6'h0F;
    localparam logic [5:0] DIV32_LOAD = 6'h1F;
    localparam logic [5:0] DIV64_LOAD = 6'h3F;

    localparam logic [2:0] SM_PAD = 3'h0;
    localparam logic [15:0] RESULT_RESET = 16'h0000;

    typedef struct packed {
        logic [4:0] positive_channel_select;
        logic [3:0] negative_channel_select;
        logic [1:0] positive_reference_select;
        logic negative_reference_select;
        logic [2:0] conversion_clock_select;
        logic result_format_select;
        logic conversion_interrupt_enable;
    } sarc_cfg_s;

    typedef struct packed {
        logic [7:0] result_high_byte;
        logic [7:0] result_low_byte;
    } sarc_result_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RC_WAIT = 2'b01,
        ST_CONVERT = 2'b10
    } sarc_state_e;

endpackage : sarc_pkg

// ===== logic/sarc_tick_gen.sv
// Purpose: Produces one pulse per bit conversion period.
// Assumes: The oscillator pin is asynchronous to the system clock.
// Notes: Divider restarts on run so the first period is a full one.
`timescale 1ns/1ps
module sarc_tick_gen (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic run,
    input wire logic [2:0] clock_select,
    input wire logic rc_osc_pin,
    output logic tick
);

    logic [2:0] rc_sync_q;
    logic rc_level_q;
    logic [5:0] div_q;
    logic use_rc;

    function automatic logic [5:0] div_load(input logic [2:0] sel);
        case (sel)
            sarc_pkg::CLK_DIV2: div_load = sarc_pkg::DIV2_LOAD;
            sarc_pkg::CLK_DIV4: div_load = sarc_pkg::DIV4_LOAD;
            sarc_pkg::CLK_DIV8: div_load = sarc_pkg::DIV8_LOAD;
            sarc_pkg::CLK_DIV16: div_load = sarc_pkg::DIV16_LOAD;
            sarc_pkg::CLK_DIV32: div_load = sarc_pkg::DIV32_LOAD;
            sarc_pkg::CLK_DIV64: div_load = sarc_pkg::DIV64_LOAD;
            default: div_load = sarc_pkg::DIV2_LOAD;
        endcase
    endfunction : div_load

    assign use_rc = (clock_select[1:0] == sarc_pkg::CLK_RC_CODE);

    // The filtered level only moves when the later two stages agree.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rc_sync_q <= 3'h0;
            rc_level_q <= 1'b0;
        end
        else
        begin
            rc_sync_q <= {rc_sync_q[1:0], rc_osc_pin};
            if (rc_sync_q[1] == rc_sync_q[2])
            begin
                rc_level_q <= rc_sync_q[2];
            end
        end
    end

    // [RULE8] Clock source select.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            div_q <= 6'h00;
            tick <= 1'b0;
        end
        else if (!run)
        begin
            div_q <= div_load(clock_select);
            tick <= 1'b0;
        end
        else if (use_rc)
        begin
            tick <= rc_sync_q[2] && !rc_level_q && (rc_sync_q[1] == rc_sync_q[2]);
        end
        else if (div_q == 6'h00)
        begin
            div_q <= div_load(clock_select);
            tick <= 1'b1;
        end
        else
        begin
            div_q <= div_q - 6'h01;
            tick <= 1'b0;
        end
    end

endmodule : sarc_tick_gen

// ===== logic/sarc_control.sv
// Purpose: Sequencing, formatting and flag logic of a 12-bit differential SAR converter.
// Assumes: Software writes appear as one-cycle pulses; the comparator pin is asynchronous.
// Notes: The bit period ticks come from the divider or the RC oscillator, resampled in sarc_tick_gen.
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] Successive approximation builds 12 bits, stored into the 16-bit result pair.
// [RULE2] Positive input follows the 5-bit positive channel field.
// [RULE3] Any positive input pairs with any negative input.
// [RULE4] Negative field all ones means single-ended conversion.
// [RULE5] Software waits a settling delay after a channel change.
// [RULE6] Positive reference is the pin, the supply or the fixed buffer.
// [RULE7] Negative reference is the pin or ground.
// [RULE8] Three-bit select picks a system clock divider or the RC oscillator.
// [RULE9] One conversion lasts fifteen bit periods.
// [RULE10] Completion flag sets after every conversion, enable or not.
// [RULE11] Only software clears the completion flag.
// [RULE12] Flag with enable raises a request, which wakes a sleeping device.
// [RULE13] Format bit picks sign-magnitude or two's complement.
// [RULE14] Sign-magnitude: magnitude in bits 15..4, zeros 3..1, sign in bit 0.
// [RULE15] Two's complement: 13-bit value right-justified and sign extended.
// [RULE16] Go with enable set clears results and starts conversion.
// [RULE17] Software never sets go in the same write that enables the module.
// [RULE18] Completion clears go/done and sets the flag.
// [RULE19] Clearing go early aborts and keeps the previous results.
// [RULE20] Reset restores all state, turns the module off, ends conversions.
// [RULE21] With the RC clock, start waits one extra instruction cycle.
// [RULE22] Sleeping on RC with interrupt off: finish, then power down.
// [RULE23] Sleep on a non-RC clock aborts and powers the converter down.
// [RULE24] Positive reference codes: 00 supply, 01 pin, 10 reserved, 11 fixed.
// [RULE25] Negative reference bit: 0 ground, 1 external pin.
// [RULE26] Go/done reads one during a conversion, zero otherwise.
// [RULE27] Go request and completion cross coherently into the bit period timing.
// [RULE28] Final result and go/done clearing happen in the same cycle.
module sarc_control (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire sarc_pkg::sarc_cfg_s cfg,
    input wire logic converter_module_enable,
    input wire logic go_set,
    input wire logic go_clear,
    input wire logic flag_clear,
    input wire logic sleep_mode,
    input wire logic rc_osc_pin,
    input wire logic comparator_pin,
    output logic go_done,
    output logic conversion_complete_flag,
    output logic interrupt_request,
    output logic wake_request,
    output sarc_pkg::sarc_result_s result,
    output logic [4:0] mux_positive,
    output logic [3:0] mux_negative,
    output logic single_ended,
    output logic [2:0] positive_ref_route,
    output logic negative_ref_external,
    output logic analog_power,
    output logic sample_hold,
    output logic [11:0] dac_code,
    output logic dac_sign
);

    sarc_pkg::sarc_state_e state_q;
    logic [3:0] phase_q;
    logic [3:0] wait_q;
    logic [2:0] cmp_sync_q;
    logic cmp_level_q;
    logic [11:0] trial_q;
    logic sign_q;
    logic sleep_off_q;
    logic tick;
    logic run;
    logic rc_clock;
    logic abort;
    logic finish;
    logic [11:0] keep_mag;
    logic [12:0] tc_value;
    logic [15:0] formatted;

    assign rc_clock = (cfg.conversion_clock_select[1:0] == sarc_pkg::CLK_RC_CODE);
    // [RULE19] Early clear aborts.
    // [RULE23] Sleep on divider aborts.
    assign abort = go_clear || !converter_module_enable || (sleep_mode && !rc_clock);
    assign run = (state_q == sarc_pkg::ST_CONVERT);
    // [RULE9] Fifteen bit periods.
    assign finish = run && tick && !abort && (phase_q == sarc_pkg::PHASE_LAST);

    // [RULE27] Bit period timing.
    sarc_tick_gen u_tick (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .run(run),
        .clock_select(cfg.conversion_clock_select),
        .rc_osc_pin(rc_osc_pin),
        .tick(tick)
    );

    // The comparator settles asynchronously, so it is resampled before use.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cmp_sync_q <= 3'h0;
            cmp_level_q <= 1'b0;
        end
        else
        begin
            cmp_sync_q <= {cmp_sync_q[1:0], comparator_pin};
            if (cmp_sync_q[1] == cmp_sync_q[2])
            begin
                cmp_level_q <= cmp_sync_q[2];
            end
        end
    end

    // Keeps the trial bit when the comparator says the input is above it.
    always_comb
    begin
        keep_mag = trial_q;
        if (phase_q >= sarc_pkg::PHASE_MSB && phase_q < sarc_pkg::PHASE_LAST && !cmp_level_q)
        begin
            keep_mag[sarc_pkg::MAG_TOP - (phase_q - sarc_pkg::PHASE_MSB)] = 1'b0;
        end
    end

    // [RULE15] Two's complement value.
    assign tc_value = sign_q ? {1'b1, 12'((~keep_mag) + 12'h001)} : {1'b0, keep_mag};

    // [RULE13] Format select.
    always_comb
    begin
        if (cfg.result_format_select)
        begin
            formatted = {{3{tc_value[12]}}, tc_value};
        end
        else
        begin
            // [RULE14] Sign-magnitude layout.
            formatted = {keep_mag, sarc_pkg::SM_PAD, sign_q};
        end
    end

    // [RULE16] Start sequence.
    // [RULE21] Extra instruction wait.
    // [RULE20] Reset ends conversion.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= sarc_pkg::ST_IDLE;
            wait_q <= 4'h0;
        end
        else
        begin
            case (state_q)
                sarc_pkg::ST_IDLE:
                begin
                    if (go_set && converter_module_enable && !(sleep_mode && !rc_clock))
                    begin
                        if (rc_clock)
                        begin
                            state_q <= sarc_pkg::ST_RC_WAIT;
                            wait_q <= sarc_pkg::RC_WAIT_LOAD;
                        end
                        else
                        begin
                            state_q <= sarc_pkg::ST_CONVERT;
                        end
                    end
                end
                sarc_pkg::ST_RC_WAIT:
                begin
                    if (abort)
                    begin
                        state_q <= sarc_pkg::ST_IDLE;
                    end
                    else if (wait_q == 4'h0)
                    begin
                        state_q <= sarc_pkg::ST_CONVERT;
                    end
                    else
                    begin
                        wait_q <= wait_q - 4'h1;
                    end
                end
                sarc_pkg::ST_CONVERT:
                begin
                    if (abort || finish)
                    begin
                        state_q <= sarc_pkg::ST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= sarc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // [RULE1] Successive approximation.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            phase_q <= sarc_pkg::PHASE_SAMPLE;
            trial_q <= 12'h000;
            sign_q <= 1'b0;
        end
        else if (!run)
        begin
            phase_q <= sarc_pkg::PHASE_SAMPLE;
            trial_q <= 12'h000;
            sign_q <= 1'b0;
        end
        else if (tick)
        begin
            phase_q <= phase_q + 4'h1;
            if (phase_q == sarc_pkg::PHASE_SIGN)
            begin
                sign_q <= !cmp_level_q;
                trial_q <= 12'h800;
            end
            else if (phase_q >= sarc_pkg::PHASE_MSB && phase_q < sarc_pkg::PHASE_LAST)
            begin
                trial_q <= keep_mag;
                if (phase_q < sarc_pkg::PHASE_LAST - 4'h1)
                begin
                    trial_q[sarc_pkg::MAG_TOP - 1 - (phase_q - sarc_pkg::PHASE_MSB)] <= 1'b1;
                end
            end
        end
    end

    // [RULE26] Go/done status.
    // [RULE18] Completion clears go.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            go_done <= 1'b0;
        end
        else if (state_q == sarc_pkg::ST_IDLE)
        begin
            go_done <= go_set && converter_module_enable && !(sleep_mode && !rc_clock);
        end
        else if (abort || finish)
        begin
            go_done <= 1'b0;
        end
    end

    // [RULE28] Result with go clear.
    // [RULE19] Abort keeps results.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            result <= sarc_pkg::RESULT_RESET;
        end
        else if (state_q == sarc_pkg::ST_IDLE && go_set && converter_module_enable)
        begin
            // [RULE16] Clear on start.
            result <= sarc_pkg::RESULT_RESET;
        end
        else if (finish)
        begin
            result <= formatted;
        end
    end

    // [RULE10] Flag on every completion.
    // [RULE11] Software-only clear.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            conversion_complete_flag <= 1'b0;
        end
        else if (finish)
        begin
            conversion_complete_flag <= 1'b1;
        end
        else if (flag_clear)
        begin
            conversion_complete_flag <= 1'b0;
        end
    end

    // [RULE12] Request and wake.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            interrupt_request <= 1'b0;
            wake_request <= 1'b0;
        end
        else
        begin
            interrupt_request <= conversion_complete_flag && cfg.conversion_interrupt_enable;
            wake_request <= conversion_complete_flag && cfg.conversion_interrupt_enable && sleep_mode;
        end
    end

    // [RULE22] Power down after finish.
    // [RULE23] Power down on abort.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sleep_off_q <= 1'b0;
            analog_power <= 1'b0;
        end
        else
        begin
            if (!sleep_mode)
            begin
                sleep_off_q <= 1'b0;
            end
            else if (!rc_clock || (finish && !cfg.conversion_interrupt_enable))
            begin
                sleep_off_q <= 1'b1;
            end
            else if (rc_clock && !cfg.conversion_interrupt_enable && state_q == sarc_pkg::ST_IDLE)
            begin
                sleep_off_q <= 1'b1;
            end
            analog_power <= converter_module_enable && !sleep_off_q;
        end
    end

    // [RULE2] Channel and reference routing.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mux_positive <= 5'h00;
            mux_negative <= 4'h0;
            single_ended <= 1'b0;
            positive_ref_route <= sarc_pkg::REF_SEL_NONE;
            negative_ref_external <= 1'b0;
        end
        else
        begin
            mux_positive <= cfg.positive_channel_select;
            // [RULE3] Free pairing.
            mux_negative <= cfg.negative_channel_select;
            // [RULE4] Single-ended detect.
            single_ended <= (cfg.negative_channel_select == sarc_pkg::NEG_SINGLE_ENDED);
            // [RULE24] Positive reference decode.
            // [RULE6] Three reference sources.
            case (cfg.positive_reference_select)
                sarc_pkg::PREF_SUPPLY: positive_ref_route <= sarc_pkg::REF_SEL_SUPPLY;
                sarc_pkg::PREF_PIN: positive_ref_route <= sarc_pkg::REF_SEL_PIN;
                sarc_pkg::PREF_FIXED: positive_ref_route <= sarc_pkg::REF_SEL_FIXED;
                default: positive_ref_route <= sarc_pkg::REF_SEL_NONE;
            endcase
            // [RULE25] Negative reference.
            // [RULE7] Pin or ground.
            negative_ref_external <= cfg.negative_reference_select;
        end
    end

    // Analog drive: sample during period zero, then the trial code.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sample_hold <= 1'b0;
            dac_code <= 12'h000;
            dac_sign <= 1'b0;
        end
        else
        begin
            sample_hold <= run && (phase_q == sarc_pkg::PHASE_SAMPLE);
            dac_code <= trial_q;
            dac_sign <= sign_q;
        end
    end

endmodule : sarc_control

// ===== tb/sarc_control_checker.sv
// Purpose: Port level checks of the converter control block.
// Assumes: Software strobes are one cycle wide.
// Notes: Tick resync makes some answers land in a small window.
`timescale 1ns/1ps
module sarc_control_checker (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire sarc_pkg::sarc_cfg_s cfg,
    input wire logic converter_module_enable,
    input wire logic go_set,
    input wire logic go_clear,
    input wire logic flag_clear,
    input wire logic sleep_mode,
    input wire logic go_done,
    input wire logic conversion_complete_flag,
    input wire logic interrupt_request,
    input wire logic wake_request,
    input wire sarc_pkg::sarc_result_s result,
    input wire logic [4:0] mux_positive,
    input wire logic [3:0] mux_negative,
    input wire logic single_ended,
    input wire logic [2:0] positive_ref_route,
    input wire logic negative_ref_external,
    input wire logic analog_power
);
    logic [2:0] route_q;
    logic [1:0] pr;
    assign pr = cfg.positive_reference_select;
    // The reserved code must route nothing, so it falls to the final default arm.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            route_q <= 3'h0;
        else
            route_q <= (pr == 2'h0) ? 3'h1 : (pr == 2'h1) ? 3'h2 : (pr == 2'h3) ? 3'h4 : 3'h0;
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_start;
        go_set && !go_clear && !go_done && converter_module_enable && $past(converter_module_enable) && !sleep_mode;
    endsequence
    sequence s_finish;
        $fell(go_done) && !$past(go_clear) && $past(converter_module_enable) && !$past(sleep_mode);
    endsequence
    a_start_clears: assert property (s_start |=> go_done && result == 16'h0000)
        else $error("start did not raise go_done with a cleared result");
    a_no_enable: assert property (!converter_module_enable && !go_done |=> !go_done)
        else $error("conversion started while disabled");
    a_flag_sticky: assert property (conversion_complete_flag && !flag_clear |=> conversion_complete_flag)
        else $error("completion flag dropped without a clear");
    a_done_flag: assert property (s_finish |-> conversion_complete_flag)
        else $error("completion without flag");
    a_abort_keep: assert property (go_done && go_clear |=> !go_done && $stable(result))
        else $error("abort changed result or kept running");
    a_irq_follow: assert property (interrupt_request == $past(conversion_complete_flag && cfg.conversion_interrupt_enable))
        else $error("interrupt request does not follow flag and enable");
    a_wake_sleep: assert property ((conversion_complete_flag && cfg.conversion_interrupt_enable && sleep_mode) [*3] |-> wake_request)
        else $error("no wake request while asleep");
    a_sm_pad: assert property (s_finish and !cfg.result_format_select |-> result[3:1] == 3'h0)
        else $error("sign-magnitude padding not zero");
    a_tc_extend: assert property (s_finish and cfg.result_format_select |-> result[15:13] == {3{result[12]}})
        else $error("two's complement not sign extended");
    a_sleep_abort: assert property (sleep_mode && go_done && cfg.conversion_clock_select[1:0] != 2'h3
        |-> ##[1:2] !go_done ##[0:3] !analog_power)
        else $error("sleep on divided clock did not abort and power down");
    a_mux_copy: assert property ($past(reset_n) |-> mux_positive == $past(cfg.positive_channel_select)
        && mux_negative == $past(cfg.negative_channel_select)
        && single_ended == ($past(cfg.negative_channel_select) == 4'hF))
        else $error("channel routing wrong");
    a_ref_route: assert property ($past(reset_n) |-> positive_ref_route == route_q
        && negative_ref_external == $past(cfg.negative_reference_select))
        else $error("reference routing wrong");
endmodule : sarc_control_checker

bind sarc_control sarc_control_checker sarc_control_checker_i (.sys_clk, .reset_n, .cfg,
    .converter_module_enable, .go_set, .go_clear, .flag_clear, .sleep_mode, .go_done,
    .conversion_complete_flag, .interrupt_request, .wake_request, .result, .mux_positive,
    .mux_negative, .single_ended, .positive_ref_route, .negative_ref_external, .analog_power);

// ===== tb/sarc_control_test.sv
// Purpose: Self-checking bench of the converter control block.
// Assumes: Comparator held constant over a conversion, so magnitudes are all ones or all zeros.
// Notes: Expected results are queued by the driver and popped when go_done falls.
`timescale 1ns/1ps
module sarc_control_test;
    logic sys_clk, reset_n, converter_module_enable, go_set, go_clear, flag_clear, sleep_mode;
    logic rc_osc_pin, comparator_pin, go_done, conversion_complete_flag, interrupt_request;
    logic wake_request, single_ended, negative_ref_external, analog_power, sample_hold, dac_sign, gd_prev, ie;
    logic [4:0] mux_positive;
    logic [3:0] mux_negative;
    logic [2:0] positive_ref_route;
    logic [11:0] dac_code;
    logic [15:0] exp_r;
    logic [16:0] nt;
    logic [16:0] notes[$];
    logic [2:0] codes[8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    int divs[8] = '{2, 4, 8, 16, 32, 64, 8, 8};
    int err_count = 0, samples_checked = 0, cyc = 0, n, t0, lo, hi;
    sarc_pkg::sarc_cfg_s cfg;
    sarc_pkg::sarc_result_s result;
    sarc_control sarc_control_i (.sys_clk, .reset_n, .cfg, .converter_module_enable, .go_set, .go_clear,
        .flag_clear, .sleep_mode, .rc_osc_pin, .comparator_pin, .go_done, .conversion_complete_flag,
        .interrupt_request, .wake_request, .result, .mux_positive, .mux_negative, .single_ended,
        .positive_ref_route, .negative_ref_external, .analog_power, .sample_hold, .dac_code, .dac_sign);
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // The oscillator runs free at eight system cycles, out of phase with the clock.
    initial
    begin
        rc_osc_pin = 1'b0;
        #7;
        forever #100 rc_osc_pin = ~rc_osc_pin;
    end
    task end_sim();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 12000)
        begin
            err_count++;
            end_sim();
        end
    end
    task chk(input string what, input logic [15:0] e, input logic [15:0] s);
        samples_checked++;
        if (s !== e)
        begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask : chk
    always @(negedge sys_clk)
    begin
        if (gd_prev === 1'b1 && go_done === 1'b0)
        begin
            nt = (notes.size() > 0) ? notes.pop_front() : 17'h1DEAD;
            chk("result", nt[15:0], result);
            chk("flag", 16'(nt[16]), 16'(conversion_complete_flag));
        end
        gd_prev = go_done;
    end
    task start_conv(input logic [2:0] cs, input logic irq_en);
        @(negedge sys_clk);
        cfg = sarc_pkg::sarc_cfg_s'(17'($urandom));
        cfg.conversion_clock_select = cs;
        cfg.conversion_interrupt_enable = irq_en;
        comparator_pin = 1'($urandom);
        exp_r = cfg.result_format_select ? (comparator_pin ? 16'h0FFF : 16'hF000)
            : (comparator_pin ? 16'hFFF0 : 16'h0001);
        repeat (4) @(negedge sys_clk);
        go_set = 1'b1;
        @(negedge sys_clk);
        go_set = 1'b0;
        t0 = cyc;
    endtask : start_conv
    task wait_done();
        n = 0;
        while (go_done !== 1'b0 && n < 1500)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 1500)
        begin
            err_count++;
            end_sim();
        end
    endtask : wait_done
    task flag_pulse();
        @(negedge sys_clk);
        flag_clear = 1'b1;
        @(negedge sys_clk);
        flag_clear = 1'b0;
    endtask : flag_pulse
    initial
    begin
        {reset_n, converter_module_enable, go_set, go_clear, flag_clear, sleep_mode, comparator_pin} = 7'h00;
        cfg = '0;
        gd_prev = 1'b0;
        void'($urandom(92));
        repeat (20) @(negedge sys_clk);
        reset_n = 1'b1;
        start_conv(3'h0, 1'b0);
        @(negedge sys_clk);
        chk("go_disabled", 16'h0, 16'(go_done));
        converter_module_enable = 1'b1;
        $display("test start refused while disabled done");
        for (int i = 0; i < 8; i++)
        begin
            start_conv(codes[i], 1'($urandom));
            notes.push_back({1'b1, exp_r});
            repeat (5) @(negedge sys_clk);
            go_set = 1'b1;
            @(negedge sys_clk);
            go_set = 1'b0;
            wait_done();
            lo = (codes[i][1:0] == 2'h3) ? 116 : 15 * divs[i] - 2;
            hi = (codes[i][1:0] == 2'h3) ? 145 : 15 * divs[i] + 6;
            chk("length", 16'h1, 16'(cyc - t0 >= lo && cyc - t0 <= hi));
            @(negedge sys_clk);
            chk("irq", 16'(cfg.conversion_interrupt_enable), 16'(interrupt_request));
            flag_pulse();
            chk("flag_clear", 16'h0, 16'(conversion_complete_flag));
            $display("test clock select %h done", codes[i]);
        end
        start_conv(3'h6, 1'b0);
        notes.push_back(17'h0);
        repeat (40) @(negedge sys_clk);
        chk("sh", 16'h1000, {2'h0, dac_sign, sample_hold, dac_code});
        go_clear = 1'b1;
        @(negedge sys_clk);
        go_clear = 1'b0;
        wait_done();
        $display("test abort done");
        start_conv(3'h1, 1'b0);
        notes.push_back(17'h0);
        repeat (20) @(negedge sys_clk);
        sleep_mode = 1'b1;
        wait_done();
        repeat (3) @(negedge sys_clk);
        chk("power_sleep", 16'h0, 16'(analog_power));
        sleep_mode = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk("power_wake", 16'h1, 16'(analog_power));
        $display("test sleep abort done");
        for (int j = 0; j < 2; j++)
        begin
            ie = (j == 0);
            start_conv(3'h3, ie);
            notes.push_back({1'b1, exp_r});
            sleep_mode = 1'b1;
            wait_done();
            repeat (3) @(negedge sys_clk);
            chk("wake", 16'(ie), 16'(wake_request));
            if (!ie)
                chk("power_rc", 16'h0, 16'(analog_power));
            sleep_mode = 1'b0;
            flag_pulse();
            $display("test sleep conversion done");
        end
        start_conv(3'h6, 1'b0);
        notes.push_back(17'h0);
        repeat (30) @(negedge sys_clk);
        reset_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        reset_n = 1'b1;
        chk("go_reset", 16'h0, 16'(go_done));
        $display("test reset done");
        end_sim();
    end
endmodule : sarc_control_test
